/* hw/plbi_defines.vh */
`ifndef PLBI_DEFINES_VH
`define PLBI_DEFINES_VH
// Framing bytes
`define PLBI_A1_BYTE 8'hF6
`define PLBI_A2_BYTE 8'h28
// Reset value of every byte register
`define PLBI_RESET_BYTE 8'h00
// Errored framing patterns that declare loss of frame
`define PLBI_OOF_ERR_COUNT 3'h4
`define PLBI_ERR_CNT_W 3
`define PLBI_ERR_CNT_ZERO 3'h0
`define PLBI_ERR_CNT_ONE 3'h1
`endif

/* hw/plbi_edge_sync.v */
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser with rising-edge detect on the synchronised level
module plbi_edge_sync (
	input wire clk_i,
	input wire rstn_i,
	input wire async_i,
	output wire level_o,
	output wire rise_o
);
	reg meta_q;
	reg sync_q;
	reg last_q;
	always @(posedge clk_i) begin
		if (!rstn_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end
	assign level_o = sync_q;
	assign rise_o = sync_q & ~last_q;
endmodule // plbi_edge_sync
`default_nettype wire

/* hw/plbi_line_if.v */
`timescale 1ns/100ps
`default_nettype none
`include "plbi_defines.vh"
// Notes on behaviour
// - Select high: parallel byte mode, bypass recovery.
// - Select low: serial mode, pins carry protection.
// - Frame-lost flag high while out of frame.
// - Four consecutive errored framing patterns declare loss.
// - Flag levels last at least one receive clock.
// - Flag drives upstream search, also readable status.
// - Input bus bit 7 first, sampled rising clock.
// - Transmit marker flags first payload byte, parallel clock.
// - Protection use: marker timed by internal clock.
// - Output bus bit 7 first, parallel clock.
// - Protection use: output timed by internal clock.
// - Internal transmit clock 77.76 MHz, even duty.
module plbi_line_if (
	input wire CORE_CLK_I,
	input wire RSTN_I,
	input wire LINE_INTERFACE_SELECT_I,
	input wire RECEIVE_LOW_RATE_SELECT_I,
	input wire TRANSMIT_LOW_RATE_SELECT_I,
	input wire PARALLEL_RECEIVE_CLOCK_I,
	input wire RECEIVE_FRAME_MARKER_I,
	input wire [7:0] RECEIVE_BYTE_BUS_I,
	input wire PARALLEL_TRANSMIT_CLOCK_I,
	input wire INTERNAL_TRANSMIT_CLOCK_I,
	input wire [7:0] TX_BYTE_I,
	input wire TX_PAYLOAD_START_I,
	output reg [7:0] RX_BYTE_O,
	output reg RX_BYTE_VALID_O,
	output reg RX_FRAME_START_O,
	output reg FRAME_LOST_FLAG_O,
	output wire FRAME_LOST_STATUS_O,
	output wire PARALLEL_MODE_O,
	output wire TX_BYTE_TAKEN_O,
	output reg [7:0] TRANSMIT_BYTE_BUS_O,
	output reg TRANSMIT_FRAME_MARKER_O
);
	// Synchronised link clocks and mode
	wire rx_clk_lvl;
	wire rx_clk_rise;
	wire ptx_lvl;
	wire ptx_rise;
	wire itx_lvl;
	wire itx_rise;
	wire mode_sel;
	wire mode_unused;
	wire rate_unused_r;
	wire rate_unused_t;

	// Receive pipeline and framing state
	reg [7:0] pin_m_q;
	reg [7:0] pin_s_q;
	reg fp_m_q;
	reg fp_s_q;
	reg [7:0] hist1_q;
	reg [7:0] hist2_q;
	reg [7:0] hist3_q;
	reg [7:0] hist4_q;
	reg [7:0] hist5_q;
	wire head_ok;
	wire pattern_ok;
	reg [`PLBI_ERR_CNT_W-1:0] err_cnt_q;
	wire is_third_a2;
	wire tx_edge;

	// Every pin from the link side is synchronised before use
	plbi_edge_sync u_rx_clk (
		.clk_i(CORE_CLK_I),
		.rstn_i(RSTN_I),
		.async_i(PARALLEL_RECEIVE_CLOCK_I),
		.level_o(rx_clk_lvl),
		.rise_o(rx_clk_rise)
	);
	plbi_edge_sync u_ptx_clk (
		.clk_i(CORE_CLK_I),
		.rstn_i(RSTN_I),
		.async_i(PARALLEL_TRANSMIT_CLOCK_I),
		.level_o(ptx_lvl),
		.rise_o(ptx_rise)
	);
	plbi_edge_sync u_itx_clk (
		.clk_i(CORE_CLK_I),
		.rstn_i(RSTN_I),
		.async_i(INTERNAL_TRANSMIT_CLOCK_I),
		.level_o(itx_lvl),
		.rise_o(itx_rise)
	);
	plbi_edge_sync u_mode (
		.clk_i(CORE_CLK_I),
		.rstn_i(RSTN_I),
		.async_i(LINE_INTERFACE_SELECT_I),
		.level_o(mode_sel),
		.rise_o(mode_unused)
	);
	// Rate selects only tell the partner which clock to supply
	assign rate_unused_r = RECEIVE_LOW_RATE_SELECT_I;
	assign rate_unused_t = TRANSMIT_LOW_RATE_SELECT_I;

	// Data pins pass two flops; they settle long before the sampled clock edge
	always @(posedge CORE_CLK_I) begin
		if (!RSTN_I) begin
			pin_m_q <= `PLBI_RESET_BYTE;
			pin_s_q <= `PLBI_RESET_BYTE;
		end else begin
			pin_m_q <= RECEIVE_BYTE_BUS_I;
			pin_s_q <= pin_m_q;
		end
	end

	always @(posedge CORE_CLK_I) begin
		if (!RSTN_I) begin
			fp_m_q <= 1'b0;
			fp_s_q <= 1'b0;
		end else begin
			fp_m_q <= RECEIVE_FRAME_MARKER_I;
			fp_s_q <= fp_m_q;
		end
	end

	assign PARALLEL_MODE_O = mode_sel;
	assign is_third_a2 = mode_sel & fp_s_q;

	// Byte capture on each receive clock rising edge, bit 7 first
	always @(posedge CORE_CLK_I) begin
		if (!RSTN_I) begin
			RX_BYTE_O <= `PLBI_RESET_BYTE;
			RX_BYTE_VALID_O <= 1'b0;
		end else begin
			RX_BYTE_VALID_O <= rx_clk_rise;
			if (rx_clk_rise) begin
				RX_BYTE_O <= pin_s_q;
			end
		end
	end

	// Frame start follows the marker in either mode
	always @(posedge CORE_CLK_I) begin
		if (!RSTN_I) begin
			RX_FRAME_START_O <= 1'b0;
		end else begin
			RX_FRAME_START_O <= rx_clk_rise & fp_s_q;
		end
	end

	// Last five bytes taken in parallel mode before the current one; only the marker sets alignment,
	// so no bit-level search is ever made on the input bus
	always @(posedge CORE_CLK_I) begin
		if (!RSTN_I) begin
			hist1_q <= `PLBI_RESET_BYTE;
			hist2_q <= `PLBI_RESET_BYTE;
			hist3_q <= `PLBI_RESET_BYTE;
			hist4_q <= `PLBI_RESET_BYTE;
			hist5_q <= `PLBI_RESET_BYTE;
		end else if (rx_clk_rise & mode_sel) begin
			hist1_q <= pin_s_q;
			hist2_q <= hist1_q;
			hist3_q <= hist2_q;
			hist4_q <= hist3_q;
			hist5_q <= hist4_q;
		end
	end

	// A good pattern is A1 A1 A1 A2 A2 followed by the marked A2
	assign head_ok = (hist5_q == `PLBI_A1_BYTE) &
		(hist4_q == `PLBI_A1_BYTE) &
		(hist3_q == `PLBI_A1_BYTE) &
		(hist2_q == `PLBI_A2_BYTE) &
		(hist1_q == `PLBI_A2_BYTE);
	assign pattern_ok = head_ok & (pin_s_q == `PLBI_A2_BYTE);

	// Errored patterns are counted on the marked byte; the fourth in a row
	// declares loss, and one clean pattern clears both count and flag
	always @(posedge CORE_CLK_I) begin
		if (!RSTN_I) begin
			err_cnt_q <= `PLBI_ERR_CNT_ZERO;
			FRAME_LOST_FLAG_O <= 1'b0;
		end else if (rx_clk_rise & is_third_a2) begin
			if (!pattern_ok) begin
				if (err_cnt_q == `PLBI_OOF_ERR_COUNT - `PLBI_ERR_CNT_ONE) begin
					FRAME_LOST_FLAG_O <= 1'b1;
					err_cnt_q <= `PLBI_OOF_ERR_COUNT;
				end else if (err_cnt_q != `PLBI_OOF_ERR_COUNT) begin
					err_cnt_q <= err_cnt_q + `PLBI_ERR_CNT_ONE;
				end
			end else begin
				err_cnt_q <= `PLBI_ERR_CNT_ZERO;
				FRAME_LOST_FLAG_O <= 1'b0;
			end
		end
	end
	// Flag only changes on a receive clock edge, so each level lasts a period
	assign FRAME_LOST_STATUS_O = FRAME_LOST_FLAG_O;

	// Transmit timing: parallel clock in parallel mode, internal clock otherwise
	assign tx_edge = mode_sel ? ptx_rise : itx_rise;
	assign TX_BYTE_TAKEN_O = tx_edge;
	always @(posedge CORE_CLK_I) begin
		if (!RSTN_I) begin
			TRANSMIT_BYTE_BUS_O <= `PLBI_RESET_BYTE;
		end else if (tx_edge) begin
			TRANSMIT_BYTE_BUS_O <= TX_BYTE_I;
		end
	end

	// Frame marker follows the same transmit edge as the byte it marks
	always @(posedge CORE_CLK_I) begin
		if (!RSTN_I) begin
			TRANSMIT_FRAME_MARKER_O <= 1'b0;
		end else if (tx_edge) begin
			TRANSMIT_FRAME_MARKER_O <= TX_PAYLOAD_START_I;
		end
	end
endmodule // plbi_line_if
`default_nettype wire

/* verif/plbi_far_end.sv */
`timescale 1ns/100ps
`default_nettype none
`include "plbi_defines.vh"
module plbi_far_end (
	output var logic ck_o,
	output var logic mk_o,
	output var logic [7:0] by_o,
	output var logic tk_o
);
	initial {ck_o, mk_o, by_o, tk_o} = 11'h000;
	always #200 tk_o = ~tk_o;
	// Three A1 then three A2; an errored run spoils the marked byte
	task automatic frame(input logic bad);
		for (int i = 0; i < 6; i++) begin
			by_o = i < 3 ? `PLBI_A1_BYTE : `PLBI_A2_BYTE ^ {7'h00, bad && i == 5};
			mk_o = i == 5;
			#200 ck_o = 1;
			#200 ck_o = 0;
		end
		mk_o = 0;
		by_o = ~by_o;
	endtask
endmodule // plbi_far_end
`default_nettype wire

/* verif/plbi_line_if_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module plbi_line_if_checker (
	input wire CORE_CLK_I,
	input wire RSTN_I,
	input wire PARALLEL_RECEIVE_CLOCK_I,
	input wire PARALLEL_TRANSMIT_CLOCK_I,
	input wire INTERNAL_TRANSMIT_CLOCK_I,
	input wire RX_BYTE_VALID_O,
	input wire RX_FRAME_START_O,
	input wire FRAME_LOST_FLAG_O,
	input wire FRAME_LOST_STATUS_O,
	input wire PARALLEL_MODE_O,
	input wire [7:0] TRANSMIT_BYTE_BUS_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RSTN_I);
	wire tx_ck = PARALLEL_MODE_O ? PARALLEL_TRANSMIT_CLOCK_I : INTERNAL_TRANSMIT_CLOCK_I;
	a_valid_pulse: assert property (RX_BYTE_VALID_O |=> !RX_BYTE_VALID_O)
		else $error("valid too long");
	a_valid_cause: assert property (RX_BYTE_VALID_O |-> $past(PARALLEL_RECEIVE_CLOCK_I, 2))
		else $error("valid without clock");
	a_start_byte: assert property (RX_FRAME_START_O |-> RX_BYTE_VALID_O)
		else $error("start off byte");
	a_flag_cause: assert property ($changed(FRAME_LOST_FLAG_O) |-> RX_BYTE_VALID_O)
		else $error("flag moved alone");
	a_flag_hold: assert property ($changed(FRAME_LOST_FLAG_O) |=> $stable(FRAME_LOST_FLAG_O) [*7])
		else $error("flag level short");
	a_status_same: assert property (FRAME_LOST_STATUS_O == FRAME_LOST_FLAG_O)
		else $error("status differs");
	a_serial_frozen: assert property (!PARALLEL_MODE_O && !$past(PARALLEL_MODE_O) |-> $stable(FRAME_LOST_FLAG_O))
		else $error("flag moved in serial");
	a_tx_timed: assert property ($changed(TRANSMIT_BYTE_BUS_O) |-> $past(tx_ck, 2))
		else $error("tx bus off edge");
endmodule // plbi_line_if_checker
bind plbi_line_if plbi_line_if_checker chk (.*);
`default_nettype wire

/* verif/tb_plbi_line_if.sv */
`timescale 1ns/100ps
`default_nettype none
`include "plbi_defines.vh"
module tb_plbi_line_if;
	logic clk, rstn, sel, rck, mk, tck, itck, tps;
	logic [7:0] rb, txb;
	wire [7:0] rx_byte, tx_bus;
	wire lost, stat, pmode, valid, fstart, taken, tmark;
	int n_valid = 0;
	int n_start = 0;
	int n_taken = 0;
	int taken_base = 0;
	int n_mismatch = 0;
	int checked = 0;
	// Rows: errored run, select, flag expected afterwards
	logic [2:0] rows [6] = '{3'b110, 3'b110, 3'b110, 3'b111, 3'b001, 3'b010};
	plbi_far_end far (.ck_o(rck), .mk_o(mk), .by_o(rb), .tk_o(tck));
	plbi_line_if dut (.CORE_CLK_I(clk), .RSTN_I(rstn), .LINE_INTERFACE_SELECT_I(sel),
		.RECEIVE_LOW_RATE_SELECT_I(1'b0), .TRANSMIT_LOW_RATE_SELECT_I(1'b0),
		.PARALLEL_RECEIVE_CLOCK_I(rck), .RECEIVE_FRAME_MARKER_I(mk), .RECEIVE_BYTE_BUS_I(rb),
		.PARALLEL_TRANSMIT_CLOCK_I(tck), .INTERNAL_TRANSMIT_CLOCK_I(itck), .TX_BYTE_I(txb),
		.TX_PAYLOAD_START_I(tps), .RX_BYTE_O(rx_byte), .RX_BYTE_VALID_O(valid),
		.RX_FRAME_START_O(fstart), .FRAME_LOST_FLAG_O(lost), .FRAME_LOST_STATUS_O(stat),
		.PARALLEL_MODE_O(pmode), .TX_BYTE_TAKEN_O(taken), .TRANSMIT_BYTE_BUS_O(tx_bus),
		.TRANSMIT_FRAME_MARKER_O(tmark));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	// Internal transmit clock runs in antiphase to the parallel one
	initial begin
		itck = 1;
		forever #200 itck = ~itck;
	end
	always @(posedge clk) begin
		if (valid) n_valid <= n_valid + 1;
		if (fstart) n_start <= n_start + 1;
		if (taken) n_taken <= n_taken + 1;
	end
	initial begin
		#100000;
		n_mismatch++;
		conclude;
	end
	initial begin
		rstn = 0;
		sel = 1;
		txb = 8'hA5;
		tps = 1;
		repeat (3) @(negedge clk);
		rstn = 1;
		foreach (rows[i]) begin
			sel = rows[i][1];
			repeat (4) @(negedge clk);
			far.frame(rows[i][2]);
			repeat (4) @(negedge clk);
			check(pmode, sel);
			check(lost, rows[i][0]);
			check(stat, rows[i][0]);
			check(rx_byte, `PLBI_A2_BYTE ^ {7'h00, rows[i][2]});
			check(8'(n_valid), 8'(6 * (i + 1)));
			check(8'(n_start), 8'(i + 1));
		end
		check(tx_bus, 8'hA5);
		check(tmark, 1);
		sel = 0;
		txb = 8'h3C;
		tps = 0;
		repeat (8) @(negedge clk);
		taken_base = n_taken;
		repeat (16) @(negedge clk);
		check(8'(n_taken - taken_base), 8'h02);
		check(tx_bus, 8'h3C);
		check(tmark, 0);
		sel = 1;
		for (int k = 0; k < 4; k++) far.frame(1);
		repeat (4) @(negedge clk);
		check(lost, 1);
		rstn = 0;
		repeat (4) @(negedge clk);
		check(lost, 0);
		check(stat, 0);
		check(tx_bus, 8'h00);
		rstn = 1;
		conclude;
	end
endmodule // tb_plbi_line_if
`default_nettype wire
